// ===== verilog/fcsm_defines.vh
// flash command sequencer constants
`ifndef FCSM_DEFINES_VH
`define FCSM_DEFINES_VH

// host register offsets
`define FCSM_REG_CMD 8'h00
`define FCSM_REG_ADDR 8'h04
`define FCSM_REG_WDATA 8'h08
`define FCSM_REG_CFG 8'h0c
`define FCSM_REG_STATUS 8'h10
`define FCSM_REG_RDATA 8'h14

// field positions
`define FCSM_CFG_BYTE_N 0
`define FCSM_CFG_ACCEL 1

// operation codes
`define FCSM_OP_READ 4'h0
`define FCSM_OP_RESET 4'h1
`define FCSM_OP_IDENT 4'h2
`define FCSM_OP_SS_ENTER 4'h3
`define FCSM_OP_SS_EXIT 4'h4
`define FCSM_OP_PROG 4'h5
`define FCSM_OP_BYP_ENTER 4'h6
`define FCSM_OP_BYP_PROG 4'h7
`define FCSM_OP_BYP_RESET 4'h8
`define FCSM_OP_HW_RESET 4'h9

// bank modes
`define FCSM_MODE_READ 2'h0
`define FCSM_MODE_IDENT 2'h1
`define FCSM_MODE_BYPASS 2'h2

// unlock and command cycle values
`define FCSM_UNL1_ADDR 32'h00000555
`define FCSM_UNL2_ADDR 32'h000002aa
`define FCSM_UNL1_DATA 16'h00aa
`define FCSM_UNL2_DATA 16'h0055
`define FCSM_CD_RESET 16'h00f0
`define FCSM_CD_IDENT 16'h0090
`define FCSM_CD_SS_ENTER 16'h0088
`define FCSM_CD_SS_EXIT 16'h0090
`define FCSM_CD_EXIT_TAIL 16'h0000
`define FCSM_CD_PROG 16'h00a0
`define FCSM_CD_BYPASS 16'h0020
`define FCSM_CD_BYP_RESET 16'h0090

// status bit positions on the data bus
`define FCSM_DQ_TOGGLE 6
`define FCSM_DQ_EXCEED 5

// strobe and reset widths in 5 ns clock cycles
`define FCSM_TWP_CYC 8'h07
`define FCSM_TACC_CYC 8'h0e
`define FCSM_TRP_CYC 8'h64
`define FCSM_TRH_CYC 8'h0a

`endif

// ===== verilog/fcsm_cycle.v
// one flash bus cycle: setup, strobe pulse, hold
`timescale 1ns/1ps
`default_nettype none
`include "fcsm_defines.vh"

module fcsm_cycle #(
    parameter AW = 21
) (
    input wire mclk,
    input wire sys_rst,
    input wire start,
    input wire abort,
    input wire is_write,
    input wire [AW-1:0] addr,
    input wire [15:0] wdata,
    output reg done,
    output reg [15:0] rdata,
    output reg [AW-1:0] fl_addr,
    output reg [15:0] fl_dq_o,
    output reg fl_dq_oe,
    input wire [15:0] fl_dq_i,
    output reg fl_ce_n,
    output reg fl_we_n,
    output reg fl_oe_n
);
    localparam C_IDLE = 2'h0;
    localparam C_SETUP = 2'h1;
    localparam C_PULSE = 2'h2;
    localparam C_HOLD = 2'h3;

    reg [1:0] st_r;
    reg [7:0] cnt_r;
    reg wr_r;

    always @(posedge mclk)
    begin
        if (sys_rst || abort)
        begin
            st_r <= C_IDLE;
            cnt_r <= 8'h00;
            wr_r <= 1'b0;
            done <= 1'b0;
            fl_dq_oe <= 1'b0;
            fl_ce_n <= 1'b1;
            fl_we_n <= 1'b1;
            fl_oe_n <= 1'b1;
            if (sys_rst)
            begin
                rdata <= 16'h0000;
                fl_addr <= {AW{1'b0}};
                fl_dq_o <= 16'h0000;
            end
        end
        else
        begin
            done <= 1'b0;
            case (st_r)
                C_IDLE:
                begin
                    if (start)
                    begin
                        // address and data settle first
                        fl_addr <= addr;
                        fl_dq_o <= wdata;
                        fl_dq_oe <= is_write;
                        wr_r <= is_write;
                        st_r <= C_SETUP;
                    end
                end
                C_SETUP:
                begin
                    // later falling edge sees a stable address
                    fl_ce_n <= 1'b0;
                    fl_we_n <= ~wr_r;
                    fl_oe_n <= wr_r;
                    cnt_r <= 8'h00;
                    st_r <= C_PULSE;
                end
                C_PULSE:
                begin
                    if (cnt_r == (wr_r ? `FCSM_TWP_CYC - 1 : `FCSM_TACC_CYC - 1))
                    begin
                        // data held past first rise
                        fl_ce_n <= 1'b1;
                        fl_we_n <= 1'b1;
                        fl_oe_n <= 1'b1;
                        if (!wr_r)
                            rdata <= fl_dq_i;
                        st_r <= C_HOLD;
                    end
                    else
                        cnt_r <= cnt_r + 8'h01;
                end
                C_HOLD:
                begin
                    fl_dq_oe <= 1'b0;
                    done <= 1'b1;
                    st_r <= C_IDLE;
                end
                default: st_r <= C_IDLE;
            endcase
        end
    end
endmodule
`default_nettype wire

// ===== verilog/fcsm_ctrl.v
// host controller that issues command sequences to a banked nor flash
// Notes on behaviour
// - identification mode left only by reset write; the code also leaves it on hardware reset (S_RREC sets read mode)
// - exceeded time needs reset; busy held until then
// - identification is two unlocks plus command
// - identification only from read, nothing busy
// - three-write entry, four-write exit, protected region
// - program is four writes, then self-timed
// - bypass entry 20h; bypass program A0h then data
// - bypass accepts only bypass program and reset
// - host writes only valid sequences
//
// Added by the designer: the address map and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "fcsm_defines.vh"

module fcsm_ctrl #(
    parameter AW = 21
) (
    input wire mclk,
    input wire sys_rst,
    input wire [7:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [31:0] reg_rdata,
    output wire [AW-1:0] fl_addr,
    output wire [15:0] fl_dq_o,
    output wire fl_dq_oe,
    input wire [15:0] fl_dq_i,
    output wire fl_ce_n,
    output wire fl_we_n,
    output wire fl_oe_n,
    output reg fl_reset_n,
    output reg fl_byte_n,
    output reg fl_accel_hv,
    input wire fl_ready_busy_n
);
    localparam S_IDLE = 3'h0;
    localparam S_SEQ = 3'h1;
    localparam S_WAITW = 3'h2;
    localparam S_POLL = 3'h3;
    localparam S_WAITP = 3'h4;
    localparam S_RST = 3'h5;
    localparam S_RREC = 3'h6;

    localparam [31:0] UNL1_A = `FCSM_UNL1_ADDR;
    localparam [31:0] UNL2_A = `FCSM_UNL2_ADDR;

    reg [2:0] state_r;
    reg [3:0] op_r;
    reg [2:0] step_r;
    reg [AW-1:0] cmd_addr_r;
    reg [15:0] cmd_data_r;
    reg [15:0] rdata_r;
    reg [1:0] mode_r;
    reg ss_map_r;
    reg reject_r;
    reg fail_r;
    reg first_r;
    reg prev_tog_r;
    reg exc_seen_r;
    reg [7:0] cnt_r;
    reg legal;
    reg [17:0] step_word;
    reg [AW-1:0] cyc_addr;

    wire cyc_done;
    wire [15:0] cyc_rdata;
    wire idle = (state_r == S_IDLE);
    wire cmd_wr = reg_wr && (reg_addr == `FCSM_REG_CMD);
    wire [3:0] new_op = reg_wdata[3:0];
    wire hw_req = cmd_wr && (new_op == `FCSM_OP_HW_RESET);
    wire accept = cmd_wr && (hw_req || (idle && legal));
    wire cyc_start = (state_r == S_SEQ) || (state_r == S_POLL);
    wire cyc_write = (state_r == S_SEQ);
    wire bypass_eff = (mode_r == `FCSM_MODE_BYPASS) || fl_accel_hv;
    wire rd_mode = (mode_r == `FCSM_MODE_READ);
    wire tog_now = cyc_rdata[`FCSM_DQ_TOGGLE];

    // write cycles per sequence
    function [2:0] op_len;
        input [3:0] op;
        begin
            case (op)
                `FCSM_OP_RESET: op_len = 3'h1;
                `FCSM_OP_IDENT: op_len = 3'h3;
                `FCSM_OP_SS_ENTER: op_len = 3'h3;
                `FCSM_OP_SS_EXIT: op_len = 3'h4;
                `FCSM_OP_PROG: op_len = 3'h4;
                `FCSM_OP_BYP_ENTER: op_len = 3'h3;
                `FCSM_OP_BYP_PROG: op_len = 3'h2;
                `FCSM_OP_BYP_RESET: op_len = 3'h2;
                default: op_len = 3'h1;
            endcase
        end
    endfunction

    // {address select, data}: 0 first unlock, 1 second unlock, 2 user address
    function [17:0] seq_word;
        input [3:0] op;
        input [2:0] step;
        input [15:0] udata;
        begin
            seq_word = {2'h2, `FCSM_CD_RESET};
            if (op == `FCSM_OP_BYP_PROG)
                seq_word = {2'h2, (step == 3'h0) ? `FCSM_CD_PROG : udata};
            else if (op == `FCSM_OP_BYP_RESET)
                seq_word = {2'h2, (step == 3'h0) ? `FCSM_CD_BYP_RESET : `FCSM_CD_EXIT_TAIL};
            else if (op != `FCSM_OP_RESET)
            begin
                case (step)
                    3'h0: seq_word = {2'h0, `FCSM_UNL1_DATA};
                    3'h1: seq_word = {2'h1, `FCSM_UNL2_DATA};
                    3'h2:
                    begin
                        case (op)
                            `FCSM_OP_IDENT: seq_word = {2'h2, `FCSM_CD_IDENT};
                            `FCSM_OP_SS_ENTER: seq_word = {2'h0, `FCSM_CD_SS_ENTER};
                            `FCSM_OP_SS_EXIT: seq_word = {2'h0, `FCSM_CD_SS_EXIT};
                            `FCSM_OP_PROG: seq_word = {2'h0, `FCSM_CD_PROG};
                            default: seq_word = {2'h0, `FCSM_CD_BYPASS};
                        endcase
                    end
                    default:
                        seq_word = {2'h2, (op == `FCSM_OP_PROG) ? udata : `FCSM_CD_EXIT_TAIL};
                endcase
            end
        end
    endfunction

    // commands legal in the mirrored mode
    always @*
    begin
        legal = 1'b0;
        case (new_op)
            `FCSM_OP_READ: legal = 1'b1;
            `FCSM_OP_RESET: legal = !bypass_eff;
            `FCSM_OP_IDENT: legal = rd_mode && !bypass_eff;
            `FCSM_OP_SS_ENTER: legal = rd_mode && !ss_map_r && !bypass_eff;
            `FCSM_OP_SS_EXIT: legal = rd_mode && ss_map_r;
            `FCSM_OP_PROG: legal = rd_mode && !bypass_eff;
            `FCSM_OP_BYP_ENTER: legal = rd_mode && !ss_map_r;
            `FCSM_OP_BYP_PROG: legal = bypass_eff;
            `FCSM_OP_BYP_RESET: legal = (mode_r == `FCSM_MODE_BYPASS) && !fl_accel_hv;
            default: legal = 1'b0;
        endcase
    end

    always @*
    begin
        step_word = seq_word(op_r, step_r, cmd_data_r);
        case (step_word[17:16])
            2'h0: cyc_addr = UNL1_A[AW-1:0];
            2'h1: cyc_addr = UNL2_A[AW-1:0];
            default: cyc_addr = cmd_addr_r;
        endcase
    end

    always @(posedge mclk)
    begin
        if (sys_rst)
        begin
            state_r <= S_IDLE;
            op_r <= `FCSM_OP_READ;
            step_r <= 3'h0;
            cmd_addr_r <= {AW{1'b0}};
            cmd_data_r <= 16'hffff;
            rdata_r <= 16'h0000;
            mode_r <= `FCSM_MODE_READ;
            ss_map_r <= 1'b0;
            reject_r <= 1'b0;
            fail_r <= 1'b0;
            first_r <= 1'b1;
            prev_tog_r <= 1'b0;
            exc_seen_r <= 1'b0;
            cnt_r <= 8'h00;
            fl_reset_n <= 1'b1;
            fl_byte_n <= 1'b1;
            fl_accel_hv <= 1'b0;
        end
        else
        begin
            if (reg_wr && idle && (reg_addr == `FCSM_REG_ADDR))
                cmd_addr_r <= reg_wdata[AW-1:0];
            if (reg_wr && idle && (reg_addr == `FCSM_REG_WDATA))
                cmd_data_r <= reg_wdata[15:0];
            if (reg_wr && idle && (reg_addr == `FCSM_REG_CFG))
            begin
                fl_byte_n <= reg_wdata[`FCSM_CFG_BYTE_N];
                fl_accel_hv <= reg_wdata[`FCSM_CFG_ACCEL] && !ss_map_r;
            end
            if (cmd_wr && !accept)
                reject_r <= 1'b1;
            if (accept)
            begin
                reject_r <= 1'b0;
                fail_r <= 1'b0;
                op_r <= new_op;
                step_r <= 3'h0;
                first_r <= 1'b1;
                exc_seen_r <= 1'b0;
                cnt_r <= 8'h00;
                if (hw_req)
                begin
                    fl_reset_n <= 1'b0;
                    state_r <= S_RST;
                end
                else if (new_op == `FCSM_OP_READ)
                    state_r <= S_POLL;
                else
                    state_r <= S_SEQ;
            end
            else
            begin
                case (state_r)
                    S_SEQ: state_r <= S_WAITW;
                    S_WAITW:
                    begin
                        if (cyc_done)
                        begin
                            if (step_r != op_len(op_r) - 3'h1)
                            begin
                                step_r <= step_r + 3'h1;
                                state_r <= S_SEQ;
                            end
                            else if ((op_r == `FCSM_OP_PROG) || (op_r == `FCSM_OP_BYP_PROG))
                                state_r <= S_POLL;
                            else
                            begin
                                state_r <= S_IDLE;
                                case (op_r)
                                    `FCSM_OP_RESET: mode_r <= `FCSM_MODE_READ;
                                    `FCSM_OP_IDENT: mode_r <= `FCSM_MODE_IDENT;
                                    `FCSM_OP_SS_ENTER: ss_map_r <= 1'b1;
                                    `FCSM_OP_SS_EXIT: ss_map_r <= 1'b0;
                                    `FCSM_OP_BYP_ENTER: mode_r <= `FCSM_MODE_BYPASS;
                                    `FCSM_OP_BYP_RESET: mode_r <= `FCSM_MODE_READ;
                                    default: mode_r <= mode_r;
                                endcase
                            end
                        end
                    end
                    S_POLL: state_r <= S_WAITP;
                    S_WAITP:
                    begin
                        if (cyc_done)
                        begin
                            rdata_r <= cyc_rdata;
                            prev_tog_r <= tog_now;
                            first_r <= 1'b0;
                            if (op_r == `FCSM_OP_READ)
                                state_r <= S_IDLE;
                            else if (!first_r && (tog_now == prev_tog_r) && fl_ready_busy_n)
                                state_r <= S_IDLE;
                            else if (!first_r && exc_seen_r && (tog_now != prev_tog_r))
                            begin
                                // still toggling after exceeded time: reset write
                                fail_r <= 1'b1;
                                op_r <= `FCSM_OP_RESET;
                                step_r <= 3'h0;
                                state_r <= S_SEQ;
                            end
                            else
                            begin
                                if (!first_r)
                                    exc_seen_r <= cyc_rdata[`FCSM_DQ_EXCEED];
                                state_r <= S_POLL;
                            end
                        end
                    end
                    S_RST:
                    begin
                        if (cnt_r == `FCSM_TRP_CYC - 1)
                        begin
                            fl_reset_n <= 1'b1;
                            cnt_r <= 8'h00;
                            state_r <= S_RREC;
                        end
                        else
                            cnt_r <= cnt_r + 8'h01;
                    end
                    S_RREC:
                    begin
                        if (cnt_r == `FCSM_TRH_CYC - 1)
                        begin
                            // hardware reset leaves banks in read mode
                            mode_r <= `FCSM_MODE_READ;
                            ss_map_r <= 1'b0;
                            state_r <= S_IDLE;
                        end
                        else
                            cnt_r <= cnt_r + 8'h01;
                    end
                    default: state_r <= S_IDLE;
                endcase
            end
        end
    end

    // register read data, one cycle after the strobe
    always @(posedge mclk)
    begin
        if (sys_rst)
            reg_rdata <= 32'h00000000;
        else if (reg_rd)
        begin
            case (reg_addr)
                `FCSM_REG_CMD: reg_rdata <= {28'h0000000, op_r};
                `FCSM_REG_ADDR: reg_rdata <= {{(32 - AW){1'b0}}, cmd_addr_r};
                `FCSM_REG_WDATA: reg_rdata <= {16'h0000, cmd_data_r};
                `FCSM_REG_CFG: reg_rdata <= {30'h00000000, fl_accel_hv, fl_byte_n};
                `FCSM_REG_STATUS: reg_rdata <= {24'h000000, fl_accel_hv, mode_r, ss_map_r,
                    fl_ready_busy_n, fail_r, reject_r, !idle};
                `FCSM_REG_RDATA: reg_rdata <= {16'h0000, rdata_r};
                default: reg_rdata <= 32'h00000000;
            endcase
        end
        else
            reg_rdata <= 32'h00000000;
    end

    fcsm_cycle #(.AW(AW)) u_cycle (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .start(cyc_start),
        .abort(hw_req),
        .is_write(cyc_write),
        .addr(cyc_write ? cyc_addr : cmd_addr_r),
        .wdata(step_word[15:0]),
        .done(cyc_done),
        .rdata(cyc_rdata),
        .fl_addr(fl_addr),
        .fl_dq_o(fl_dq_o),
        .fl_dq_oe(fl_dq_oe),
        .fl_dq_i(fl_dq_i),
        .fl_ce_n(fl_ce_n),
        .fl_we_n(fl_we_n),
        .fl_oe_n(fl_oe_n)
    );
endmodule
`default_nettype wire

// ===== sim/fcsm_ctrl_sva.sv
// port assertions for the flash command sequencer
`timescale 1ns/1ps
`default_nettype none
module fcsm_ctrl_chk #(
    parameter AW = 21
) (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic [AW-1:0] fl_addr,
    input wire logic [15:0] fl_dq_o,
    input wire logic fl_dq_oe,
    input wire logic fl_ce_n,
    input wire logic fl_we_n,
    input wire logic fl_oe_n,
    input wire logic fl_reset_n,
    input wire logic fl_accel_hv
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (sys_rst);
    // a hardware reset may cut a strobe short
    chk_we_width:
        assert property ($fell(fl_we_n) |-> ((!fl_we_n)[*7] ##1 fl_we_n) or (##[0:8] !fl_reset_n))
        else $error("we width");
    chk_oe_width:
        assert property ($fell(fl_oe_n) |-> (##13 !fl_oe_n ##1 fl_oe_n) or (##[0:15] !fl_reset_n))
        else $error("oe width");
    chk_wr_hold:
        assert property (!fl_we_n && !$past(fl_we_n) |-> $stable(fl_dq_o) && $stable(fl_addr) && fl_dq_oe)
        else $error("write hold");
    chk_addr_setup:
        assert property ($fell(fl_we_n) || $fell(fl_oe_n) |-> $stable(fl_addr))
        else $error("addr setup");
    chk_strobe_excl:
        assert property (!(!fl_we_n && !fl_oe_n))
        else $error("strobe overlap");
    chk_ce_select:
        assert property (!fl_we_n || !fl_oe_n |-> !fl_ce_n)
        else $error("no select");
    chk_rst_pulse:
        assert property ($fell(fl_reset_n) |-> ##98 !fl_reset_n)
        else $error("reset short");
    chk_rst_quiet:
        assert property (!fl_reset_n && !$past(fl_reset_n) |-> fl_we_n && fl_oe_n && !fl_dq_oe)
        else $error("bus in reset");
    chk_rdata_idle:
        assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
        else $error("stray rdata");
    chk_accel_src:
        assert property ($rose(fl_accel_hv) |-> $past(reg_wr) || $past(reg_wr, 2))
        else $error("stray accel");
    cov_write: cover property ($fell(fl_we_n));
    cov_read: cover property ($fell(fl_oe_n));
    cov_hwrst: cover property ($fell(fl_reset_n));
endmodule
bind fcsm_ctrl fcsm_ctrl_chk #(.AW(AW)) fcsm_ctrl_chk_i (.mclk(mclk), .sys_rst(sys_rst),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .fl_addr(fl_addr),
    .fl_dq_o(fl_dq_o), .fl_dq_oe(fl_dq_oe), .fl_ce_n(fl_ce_n), .fl_we_n(fl_we_n),
    .fl_oe_n(fl_oe_n), .fl_reset_n(fl_reset_n), .fl_accel_hv(fl_accel_hv));
`default_nettype wire

// ===== sim/fcsm_flash_model.sv
// behavioural banked flash device seen by the sequencer
`timescale 1ns/1ps
`default_nettype none
`include "fcsm_defines.vh"
module fcsm_flash_model #(
    parameter AW = 21,
    parameter PROG_CYC = 40,
    parameter [15:0] ID_CODE = 16'h00a5, // arbitrary value
    parameter [15:0] REGION_WORD = 16'h005a
) (
    input wire logic mclk,
    input wire logic [AW-1:0] fl_addr,
    input wire logic [15:0] dq_in,
    output logic [15:0] dq_out,
    input wire logic fl_ce_n,
    input wire logic fl_we_n,
    input wire logic fl_oe_n,
    input wire logic fl_reset_n,
    input wire logic fl_byte_n,
    input wire logic fl_accel_hv,
    output logic ready_busy_n,
    input wire logic fail_en
);
    logic [15:0] mem [0:255];
    logic [AW-1:0] la = '0;
    logic [1:0] step = 2'h0;
    logic wr_act = 0, rd_act = 0, ident = 0, region = 0, bypass = 0, bp_rst = 0;
    logic prog_arm = 0, exit_arm = 0, busy = 0, exceed = 0, tog = 0;
    logic [15:0] pdata = 16'hffff, last_v = 16'h0;
    integer cnt = 0;
    wire acc = fl_accel_hv && !region;
    wire drv = !fl_ce_n && !fl_oe_n;
    wire [15:0] sts = {8'h00, ~pdata[7], tog, exceed, 5'h00};
    wire [15:0] rv = busy ? sts : ident ? ID_CODE : region ? REGION_WORD : mem[fl_addr[7:0]];
    assign dq_out = drv ? rv : ~last_v;
    assign ready_busy_n = !busy;
    initial
    begin
        for (int i = 0; i < 256; i++) mem[i] = 16'hffff;
    end
    task automatic cmd(input logic [AW-1:0] a, input logic [15:0] d);
        if (busy)
        begin
            if (exceed && d == `FCSM_CD_RESET) {busy, exceed} <= 2'b00;
        end
        else if (prog_arm)
        begin
            prog_arm <= 0;
            pdata <= d;
            mem[a[7:0]] <= mem[a[7:0]] & (fl_byte_n ? d : d | 16'hff00);
            busy <= 1;
            exceed <= fail_en;
            cnt <= PROG_CYC;
        end
        else if (bypass || acc)
        begin
            bp_rst <= 0;
            if (bp_rst && d == `FCSM_CD_EXIT_TAIL) bypass <= 0;
            else if (!bp_rst && d == `FCSM_CD_PROG) prog_arm <= 1;
            else if (!bp_rst && d == `FCSM_CD_BYP_RESET) bp_rst <= 1;
        end
        else if (d == `FCSM_CD_RESET) {step, ident} <= 3'h0;
        else if (exit_arm)
        begin
            exit_arm <= 0;
            if (d == `FCSM_CD_EXIT_TAIL) region <= 0;
        end
        else if (step == 2'h0) step <= (32'(a) == `FCSM_UNL1_ADDR && d == `FCSM_UNL1_DATA) ? 1 : 0;
        else if (step == 2'h1) step <= (32'(a) == `FCSM_UNL2_ADDR && d == `FCSM_UNL2_DATA) ? 2 : 0;
        else
        begin
            step <= 0;
            if (d == `FCSM_CD_SS_EXIT && region) exit_arm <= 1;
            else if (d == `FCSM_CD_IDENT) ident <= 1;
            else if (d == `FCSM_CD_SS_ENTER) region <= 1;
            else if (d == `FCSM_CD_PROG) prog_arm <= 1;
            else if (d == `FCSM_CD_BYPASS && !region) bypass <= 1;
        end
    endtask
    always @(posedge mclk)
    begin
        wr_act <= !fl_ce_n && !fl_we_n;
        rd_act <= drv;
        if (drv) last_v <= rv;
        if (!fl_reset_n)
        begin
            {ident, region, bypass, bp_rst, prog_arm, exit_arm, busy, exceed} <= 8'h00;
            step <= 0;
        end
        else
        begin
            if (rd_act && !drv && busy) tog <= !tog;
            if (busy && !exceed) cnt <= cnt - 1;
            if (busy && !exceed && cnt == 1) busy <= 0;
            if (!fl_ce_n && !fl_we_n && !wr_act) la <= fl_addr;
            if (wr_act && (fl_ce_n || fl_we_n)) cmd(la, dq_in);
        end
    end
endmodule
`default_nettype wire

// ===== sim/tb_fcsm_ctrl.sv
// self-checking bench for the flash command sequencer
`timescale 1ns/1ps
`default_nettype none
`include "fcsm_defines.vh"
module tb_fcsm_ctrl;
    localparam AW = 21;
    logic mclk = 0, sys_rst = 1, reg_wr = 0, reg_rd = 0, fail_en = 0, rd_pend = 0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0, last_rd = 32'h0;
    logic [63:0] e_cur, exp_q[$];
    logic [15:0] d1, d2;
    integer num_errors = 0, checked = 0, seed = 99;
    wire [31:0] reg_rdata;
    wire [AW-1:0] fl_addr;
    wire [15:0] fl_dq_o, mdl_dq, dq_bus;
    wire fl_dq_oe, fl_ce_n, fl_we_n, fl_oe_n, fl_reset_n, fl_byte_n, fl_accel_hv, rdy_n;
    assign dq_bus = fl_dq_oe ? fl_dq_o : mdl_dq;
    always #2.5 mclk = ~mclk;
    fcsm_ctrl #(.AW(AW)) fcsm_ctrl_i (.mclk(mclk), .sys_rst(sys_rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .fl_addr(fl_addr), .fl_dq_o(fl_dq_o), .fl_dq_oe(fl_dq_oe), .fl_dq_i(dq_bus),
        .fl_ce_n(fl_ce_n), .fl_we_n(fl_we_n), .fl_oe_n(fl_oe_n), .fl_reset_n(fl_reset_n),
        .fl_byte_n(fl_byte_n), .fl_accel_hv(fl_accel_hv), .fl_ready_busy_n(rdy_n));
    fcsm_flash_model #(.AW(AW)) fcsm_flash_model_i (.mclk(mclk), .fl_addr(fl_addr),
        .dq_in(dq_bus), .dq_out(mdl_dq), .fl_ce_n(fl_ce_n), .fl_we_n(fl_we_n),
        .fl_oe_n(fl_oe_n), .fl_reset_n(fl_reset_n), .fl_byte_n(fl_byte_n),
        .fl_accel_hv(fl_accel_hv), .ready_busy_n(rdy_n), .fail_en(fail_en));
    task check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task finish_test;
        $display("comparisons %0d, mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        reg_wr <= 1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 0;
        @(posedge mclk);
    endtask
    // note queued for the monitor
    task rd(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] mask);
        reg_rd <= 1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 0;
        exp_q.push_back({mask, exp});
        @(negedge mclk);
        last_rd = reg_rdata;
        @(posedge mclk);
    endtask
    always @(posedge mclk)
    begin
        if (rd_pend)
        begin
            e_cur = exp_q.pop_front();
            check(reg_rdata & e_cur[63:32], e_cur[31:0] & e_cur[63:32]);
        end
        rd_pend <= reg_rd;
    end
    task sts(input logic [31:0] exp, input logic [31:0] mask);
        rd(`FCSM_REG_STATUS, exp, mask);
    endtask
    task cmd(input logic [3:0] op);
        integer n;
        wr(`FCSM_REG_CMD, {28'h0, op});
        n = 0;
        last_rd = 32'h1;
        while (last_rd[0] && n < 300)
        begin
            sts(32'h0, 32'h0);
            n++;
        end
        if (last_rd[0]) check(last_rd, 32'h0);
    endtask
    task put(input logic [7:0] a, input logic [15:0] d);
        wr(`FCSM_REG_ADDR, {24'h0, a});
        wr(`FCSM_REG_WDATA, {16'h0, d});
    endtask
    task arr(input logic [7:0] a, input logic [15:0] exp);
        wr(`FCSM_REG_ADDR, {24'h0, a});
        cmd(4'h0);
        rd(`FCSM_REG_RDATA, {16'h0, exp}, 32'hffff);
    endtask
    initial
    begin
        #200000;
        num_errors++;
        finish_test;
    end
    initial
    begin
        repeat (5) @(posedge mclk);
        sys_rst <= 0;
        @(posedge mclk);
        sts(32'h08, 32'hff);
        rd(`FCSM_REG_WDATA, 32'hffff, 32'hffff);
        rd(8'h20, 32'h0, 32'hffffffff);
        $display("test reset done");
        d1 = $random(seed);
        d2 = $random(seed);
        put(8'h12, d1);
        cmd(4'h5);
        sts(32'h08, 32'hff);
        arr(8'h12, d1);
        put(8'h12, d2);
        wr(`FCSM_REG_CMD, 32'h5);
        cmd(4'h2);
        sts(32'h0a, 32'hff);
        arr(8'h12, d1 & d2);
        wr(`FCSM_REG_CFG, 32'h0);
        put(8'h40, d1);
        cmd(4'h5);
        wr(`FCSM_REG_CFG, 32'h1);
        arr(8'h40, {8'hff, d1[7:0]});
        $display("test program done");
        cmd(4'h2);
        sts(32'h28, 32'hff);
        arr(8'h12, fcsm_flash_model_i.ID_CODE);
        arr(8'h41, fcsm_flash_model_i.ID_CODE);
        put(8'h50, d1);
        cmd(4'h5);
        sts(32'h2a, 32'hff);
        cmd(4'h1);
        sts(32'h08, 32'hff);
        arr(8'h12, d1 & d2);
        $display("test ident done");
        cmd(4'h3);
        sts(32'h18, 32'hff);
        arr(8'h12, fcsm_flash_model_i.REGION_WORD);
        wr(`FCSM_REG_CFG, 32'h3);
        rd(`FCSM_REG_CFG, 32'h1, 32'h3);
        cmd(4'h6);
        sts(32'h1a, 32'hff);
        cmd(4'h4);
        sts(32'h08, 32'h7f);
        arr(8'h12, d1 & d2);
        $display("test region done");
        cmd(4'h6);
        sts(32'h48, 32'hff);
        put(8'h60, d2);
        cmd(4'h7);
        arr(8'h60, d2);
        cmd(4'h5);
        sts(32'h4a, 32'hff);
        cmd(4'h8);
        sts(32'h08, 32'hff);
        wr(`FCSM_REG_CFG, 32'h3);
        sts(32'h88, 32'h8f);
        put(8'h70, d1);
        cmd(4'h7);
        arr(8'h70, d1);
        wr(`FCSM_REG_CFG, 32'h1);
        $display("test bypass done");
        fail_en <= 1;
        put(8'h78, d2);
        cmd(4'h5);
        sts(32'h0c, 32'h0f);
        fail_en <= 0;
        put(8'h7a, d1);
        wr(`FCSM_REG_CMD, 32'h5);
        cmd(4'h9);
        sts(32'h08, 32'h7f);
        cmd(4'hf);
        sts(32'h02, 32'h03);
        $display("test fault done");
        finish_test;
    end
endmodule
`default_nettype wire
